/* src/epmt_map.vh */
// Purpose: Register map, field positions, reset values and codes for
//          the event and pulse measurement timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef EPMT_MAP_VH
`define EPMT_MAP_VH

// Register byte offsets
`define EPMT_ADDR_W           5
`define EPMT_OFS_CTRL         5'h00
`define EPMT_OFS_IOC          5'h04
`define EPMT_OFS_MODE         5'h08
`define EPMT_OFS_RELOAD       5'h0c
`define EPMT_OFS_GSRC         5'h10

// timer_control_reg fields
`define EPMT_CTRL_RUN         0
`define EPMT_CTRL_STAT        1
`define EPMT_CTRL_EDGF        4
`define EPMT_CTRL_UNDF        5

// io_control_reg fields
`define EPMT_IOC_POL          0
`define EPMT_IOC_STOP         1
`define EPMT_IOC_FLT_LO       2
`define EPMT_IOC_FLT_HI       3
`define EPMT_IOC_GATE_LO      4
`define EPMT_IOC_GATE_HI      5
`define EPMT_IOC_OEN          6
`define EPMT_IOC_RESET        7'h00

// timer_mode_reg fields
`define EPMT_MODE_LO          0
`define EPMT_MODE_HI          2
`define EPMT_CLK_LO           4
`define EPMT_CLK_HI           6

// Operating modes
`define EPMT_MD_TIMER         3'h0
`define EPMT_MD_PULSE_OUT     3'h1
`define EPMT_MD_EVENT         3'h2
`define EPMT_MD_WIDTH         3'h3
`define EPMT_MD_PERIOD        3'h4

// Count source codes
`define EPMT_CK_DIV1          3'h0
`define EPMT_CK_DIV8          3'h1
`define EPMT_CK_DIV2          3'h3
`define EPMT_CK_LINK          3'h5
`define EPMT_CK_DIV32         3'h7

// Filter and gate codes
`define EPMT_FLT_NONE         2'h0
`define EPMT_FLT_DIV1         2'h1
`define EPMT_FLT_DIV8         2'h2
`define EPMT_FLT_DIV32        2'h3
`define EPMT_GATE_NONE        2'h0
`define EPMT_GATE_PIN         2'h1
`define EPMT_GATE_PWM         2'h2

// Reset value, widths and filter taps
`define EPMT_RELOAD_RESET     16'hffff
`define EPMT_CNT_W            16
`define EPMT_PRE_W            5
`define EPMT_FILTER_TAPS      3

`endif

/* src/epmt_filter.v */
// Purpose: Pin synchroniser and three-sample digital noise filter.
// Assumes: pin is asynchronous to pclk; sample_en is a one-cycle pulse, or held high to sample every cycle.
// Notes:   With bypass high the synchronised level is used directly.
`timescale 1ns/1ps
module epmt_filter (
  input  wire pclk,
  input  wire presetn,
  input  wire pin,
  input  wire sample_en,
  input  wire bypass,
  output wire level
);

  reg       sync_1;
  reg       sync_2;
  reg       sync_3;
  reg       sync_level;
  reg [2:0] hist;
  reg       flt_level;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_1     <= 1'b0;
      sync_2     <= 1'b0;
      sync_3     <= 1'b0;
      sync_level <= 1'b0;
    end else begin
      sync_1 <= pin;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      if (sync_2 == sync_3)
        sync_level <= sync_3;
    end
  end

  // Level accepted only after three equal samples at the chosen rate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist      <= 3'h0;
      flt_level <= 1'b0;
    end else if (sample_en) begin
      hist <= {hist[1:0], sync_level};
      if (hist == 3'h7)
        flt_level <= 1'b1;
      else if (hist == 3'h0)
        flt_level <= 1'b0;
    end
  end

  assign level = bypass ? sync_level : flt_level;

endmodule // epmt_filter

/* src/epmt_timer.v */
// Purpose: 16-bit down counter with event counting, pulse width and
//          pulse period measurement, pin decode and APB registers.
// Assumes: pclk 200 MHz; gate_pwm and link_event are on pclk.
// Notes:   Reads of the reload word return the counter, or the
//          read-out buffer in period mode.
`timescale 1ns/1ps
`include "epmt_map.vh"

// Functional notes
// - Event counter mode 010b decrements once per valid timer pin event.
// - Gate select 01b or 10b counts events only inside the gating period.
// - Optional digital filter cleans the timer pin input before use.
// - Dedicated output pin keeps toggling in event counter mode.
// - With io control 00h, events count on the pin's rising edge.
// - Width mode decrements while the pin shows the chosen level.
// - End of chosen level stops count, sets edge flag, raises interrupt.
// - Underflow during width measurement sets underflow flag, interrupt.
// - Period edge copies count into read-out buffer at next tick.
// - Tick after the copy reloads counter, sets edge flag, interrupts.
// - Captured period stays in the buffer until software reads it.
// - Underflow in period mode sets underflow flag and interrupts.
// - Link clock source decrements on each rising edge of link event.
// - Output pin disabled when enable is 0, else polarity-inverted.
// - Io pin is input except in pulse output mode, per stop and polarity.
// - Measurement flags clear only by writing 0; writing 1 keeps them.
module epmt_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        timer_io_pin_in,
  output reg         timer_io_pin_out,
  output reg         timer_io_pin_oe,
  output reg         timer_out_pin,
  output reg         timer_out_pin_oe,
  input  wire        gate_int_pin,
  input  wire [3:0]  gate_pwm,
  input  wire        link_event,
  output reg         timer_irq
);

  // Registers
  reg        run_request;
  reg        count_status;
  reg        active_edge_flag;
  reg        underflow_flag;
  reg [6:0]  io_control_reg;
  reg [2:0]  mode_sel;
  reg [2:0]  clk_sel;
  reg [1:0]  gate_source_select_reg;
  reg [15:0] counter_reload_value;
  reg [15:0] counter;
  reg [15:0] readout_buf;
  reg        buf_held;
  reg        period_edge_pend;
  reg        xfer_pend;
  reg        out_level;
  reg [`EPMT_PRE_W-1:0] prescale;
  reg        link_prev;
  reg        io_prev;
  reg        gate_pin_sync_1;
  reg        gate_pin_sync_2;
  reg        gate_pin_sync_3;
  reg        gate_pin_level;

  wire       io_level;
  wire       level_polarity_select = io_control_reg[`EPMT_IOC_POL];
  wire       io_pin_output_stop    = io_control_reg[`EPMT_IOC_STOP];
  wire       output_pin_enable     = io_control_reg[`EPMT_IOC_OEN];
  wire [1:0] filter_sel = io_control_reg[`EPMT_IOC_FLT_HI:`EPMT_IOC_FLT_LO];
  wire [1:0] gate_sel   = io_control_reg[`EPMT_IOC_GATE_HI:`EPMT_IOC_GATE_LO];

  // Tick of a divided rate from the free prescaler
  function div_tick;
    input [2:0]             sel;
    input [`EPMT_PRE_W-1:0] pc;
    begin
      case (sel)
        `EPMT_CK_DIV2: div_tick = (pc[0] == 1'b1);
        `EPMT_CK_DIV8: div_tick = (pc[2:0] == 3'h7);
        `EPMT_CK_DIV32: div_tick = (pc == 5'h1f);
        default:       div_tick = 1'b1;
      endcase
    end
  endfunction

  // APB decode
  wire        apb_setup  = psel && !penable;
  wire        apb_access = psel && penable && pready;
  wire        apb_wr     = apb_access && pwrite && !pslverr;
  wire        apb_rd     = apb_access && !pwrite && !pslverr;
  wire [4:0]  reg_addr   = paddr[`EPMT_ADDR_W-1:0];
  wire        addr_ok    = (paddr[31:`EPMT_ADDR_W] == 27'h0) &&
                           (reg_addr[1:0] == 2'h0) &&
                           (reg_addr <= `EPMT_OFS_GSRC);
  wire        wr_ctrl    = apb_wr && (reg_addr == `EPMT_OFS_CTRL);
  wire        wr_reload  = apb_wr && (reg_addr == `EPMT_OFS_RELOAD);
  wire        rd_reload  = apb_rd && (reg_addr == `EPMT_OFS_RELOAD);

  wire        is_event   = (mode_sel == `EPMT_MD_EVENT);
  wire        is_width   = (mode_sel == `EPMT_MD_WIDTH);
  wire        is_period  = (mode_sel == `EPMT_MD_PERIOD);
  wire        is_measure = is_width || is_period;

  // Filter sampling rate
  reg flt_sample;
  always @* begin
    case (filter_sel)
      `EPMT_FLT_DIV8:  flt_sample = div_tick(`EPMT_CK_DIV8, prescale);
      `EPMT_FLT_DIV32: flt_sample = div_tick(`EPMT_CK_DIV32, prescale);
      default:         flt_sample = 1'b1;
    endcase
  end

  epmt_filter u_io_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin       (timer_io_pin_in),
    .sample_en (flt_sample),
    .bypass    (filter_sel == `EPMT_FLT_NONE),
    .level     (io_level)
  );

  // Gate pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_pin_sync_1 <= 1'b0;
      gate_pin_sync_2 <= 1'b0;
      gate_pin_sync_3 <= 1'b0;
      gate_pin_level  <= 1'b0;
    end else begin
      gate_pin_sync_1 <= gate_int_pin;
      gate_pin_sync_2 <= gate_pin_sync_1;
      gate_pin_sync_3 <= gate_pin_sync_2;
      if (gate_pin_sync_2 == gate_pin_sync_3)
        gate_pin_level <= gate_pin_sync_3;
    end
  end

  reg gate_open;
  always @* begin
    case (gate_sel)
      `EPMT_GATE_PIN: gate_open = gate_pin_level;
      `EPMT_GATE_PWM: gate_open = gate_pwm[gate_source_select_reg];
      default:        gate_open = 1'b1;
    endcase
  end

  // Edges of the filtered pin; polarity 0 picks rising edge and high level
  wire io_rise     = io_level && !io_prev;
  wire io_fall     = !io_level && io_prev;
  wire io_act_lvl  = io_level ^ level_polarity_select;
  wire io_act_edge = level_polarity_select ? io_fall : io_rise;
  wire io_lvl_end  = level_polarity_select ? io_rise : io_fall;
  wire link_rise   = link_event && !link_prev;

  // Count source tick
  wire src_tick = (clk_sel == `EPMT_CK_LINK) ? link_rise
                                             : div_tick(clk_sel, prescale);

  reg dec_tick;
  always @* begin
    if (!count_status)
      dec_tick = 1'b0;
    else if (is_event)
      dec_tick = io_act_edge && gate_open;
    else if (is_width)
      dec_tick = src_tick && io_act_lvl;
    else
      dec_tick = src_tick;
  end

  wire underflow   = dec_tick && (counter == 16'h0000);
  wire edge_set    = count_status &&
                     ((is_width && io_lvl_end) ||
                      (is_period && xfer_pend && src_tick));
  wire undf_set    = underflow && is_measure;
  wire capture     = count_status && is_period && src_tick &&
                     period_edge_pend && !xfer_pend;

  // Flags: hardware set wins over a software clear
  wire next_edge_flag = edge_set || (active_edge_flag &&
                        !(wr_ctrl && !pwdata[`EPMT_CTRL_EDGF]));
  wire next_undf_flag = undf_set || (underflow_flag &&
                        !(wr_ctrl && !pwdata[`EPMT_CTRL_UNDF]));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale         <= {`EPMT_PRE_W{1'b0}};
      link_prev        <= 1'b0;
      io_prev          <= 1'b0;
      count_status     <= 1'b0;
      active_edge_flag <= 1'b0;
      underflow_flag   <= 1'b0;
    end else begin
      prescale         <= prescale + 5'h01;
      link_prev        <= link_event;
      io_prev          <= io_level;
      count_status     <= run_request;
      active_edge_flag <= next_edge_flag;
      underflow_flag   <= next_undf_flag;
    end
  end

  // Software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_request            <= 1'b0;
      io_control_reg         <= `EPMT_IOC_RESET;
      mode_sel               <= `EPMT_MD_TIMER;
      clk_sel                <= `EPMT_CK_DIV1;
      gate_source_select_reg <= 2'h0;
      counter_reload_value   <= `EPMT_RELOAD_RESET;
    end else if (apb_wr) begin
      case (reg_addr)
        `EPMT_OFS_CTRL:   run_request <= pwdata[`EPMT_CTRL_RUN];
        `EPMT_OFS_IOC:    io_control_reg <= pwdata[6:0];
        `EPMT_OFS_MODE: begin
          mode_sel <= pwdata[`EPMT_MODE_HI:`EPMT_MODE_LO];
          clk_sel  <= pwdata[`EPMT_CLK_HI:`EPMT_CLK_LO];
        end
        `EPMT_OFS_RELOAD: counter_reload_value <= pwdata[15:0];
        `EPMT_OFS_GSRC:   gate_source_select_reg <= pwdata[1:0];
        default:          run_request <= run_request;
      endcase
    end
  end

  // Counter, read-out buffer and period capture sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter          <= `EPMT_RELOAD_RESET;
      readout_buf      <= 16'h0000;
      buf_held         <= 1'b0;
      period_edge_pend <= 1'b0;
      xfer_pend        <= 1'b0;
    end else begin
      if (wr_reload && !run_request)
        counter <= pwdata[15:0];
      else if (edge_set && is_period)
        counter <= counter_reload_value;
      else if (underflow)
        counter <= counter_reload_value;
      else if (dec_tick)
        counter <= counter - 16'h0001;

      if (!is_period || !count_status)
        period_edge_pend <= 1'b0;
      else if (io_act_edge)
        period_edge_pend <= 1'b1;
      else if (capture)
        period_edge_pend <= 1'b0;

      if (!is_period || !count_status)
        xfer_pend <= 1'b0;
      else if (capture)
        xfer_pend <= 1'b1;
      else if (src_tick)
        xfer_pend <= 1'b0;

      if (capture && !buf_held) begin
        readout_buf <= counter;
        buf_held    <= 1'b1;
      end else if (rd_reload && is_period) begin
        buf_held <= 1'b0;
      end
    end
  end

  // Pin and interrupt outputs, all from flip-flops
  wire next_out_level = underflow ? !out_level : out_level;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level        <= 1'b0;
      timer_out_pin    <= 1'b0;
      timer_out_pin_oe <= 1'b0;
      timer_io_pin_out <= 1'b0;
      timer_io_pin_oe  <= 1'b0;
      timer_irq        <= 1'b0;
    end else begin
      out_level        <= next_out_level;
      timer_out_pin    <= next_out_level ^ level_polarity_select;
      timer_out_pin_oe <= output_pin_enable;
      timer_io_pin_out <= next_out_level ^ !level_polarity_select;
      timer_io_pin_oe  <= (mode_sel == `EPMT_MD_PULSE_OUT) &&
                          !io_pin_output_stop;
      timer_irq        <= is_measure &&
                          (next_edge_flag || next_undf_flag);
    end
  end

  // APB answer: one cycle after setup, registered
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (reg_addr)
      `EPMT_OFS_CTRL: begin
        rd_mux[`EPMT_CTRL_RUN]  = run_request;
        rd_mux[`EPMT_CTRL_STAT] = count_status;
        rd_mux[`EPMT_CTRL_EDGF] = active_edge_flag;
        rd_mux[`EPMT_CTRL_UNDF] = underflow_flag;
      end
      `EPMT_OFS_IOC:    rd_mux[6:0] = io_control_reg;
      `EPMT_OFS_MODE: begin
        rd_mux[`EPMT_MODE_HI:`EPMT_MODE_LO] = mode_sel;
        rd_mux[`EPMT_CLK_HI:`EPMT_CLK_LO]   = clk_sel;
      end
      `EPMT_OFS_RELOAD: rd_mux[15:0] = is_period ? readout_buf : counter;
      `EPMT_OFS_GSRC:   rd_mux[1:0] = gate_source_select_reg;
      default:          rd_mux = 32'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (apb_setup) begin
      pready  <= 1'b1;
      pslverr <= !addr_ok;
      prdata  <= (addr_ok && !pwrite) ? rd_mux : 32'h0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // epmt_timer

/* bench/epmt_chk.sv */
// Purpose: Port-level checks for the event and pulse measurement timer.
// Assumes: Only the top module's ports are visible.
// Notes:   Shadows of io control and mode follow committed APB writes.
`timescale 1ns/1ps
module epmt_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        timer_io_pin_oe,
  input wire        timer_out_pin_oe,
  input wire        timer_irq
);
  wire       commit = psel & penable & pready & pwrite & ~pslverr;
  reg  [6:0] ioc;
  reg  [2:0] md;
  reg  [1:0] quiet;

  // Registered pin enables settle a few cycles after any write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ioc   <= 7'h00;
      md    <= 3'h0;
      quiet <= 2'h3;
    end else begin
      if (commit && paddr == 32'h4) ioc <= pwdata[6:0];
      if (commit && paddr == 32'h8) md <= pwdata[2:0];
      quiet <= commit ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence

  property p_apb_answer;
    s_setup |=> s_answer ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("slave answer late or longer than one cycle");
  property p_refuse;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("error response without ready or with data");
  property p_out_oe;
    quiet == 2'h3 |-> timer_out_pin_oe == ioc[6];
  endproperty
  a_out_oe: assert property (p_out_oe)
    else $error("output pin enable differs from its control bit");
  property p_io_in;
    quiet == 2'h3 && md != 3'h1 |-> !timer_io_pin_oe;
  endproperty
  a_io_in: assert property (p_io_in)
    else $error("io pin driven outside pulse output mode");
  property p_io_pulse;
    quiet == 2'h3 && md == 3'h1 |-> timer_io_pin_oe == !ioc[1];
  endproperty
  a_io_pulse: assert property (p_io_pulse)
    else $error("io pin enable wrong in pulse output mode");
  property p_irq_mode;
    quiet == 2'h3 && md < 3'h3 |-> !timer_irq;
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("interrupt raised outside measurement modes");
  property p_irq_rise;
    $rose(timer_irq) |-> md == 3'h3 || md == 3'h4;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose outside measurement modes");
  property p_irq_clear;
    $fell(timer_irq) |-> $past(commit) || $past(commit, 2)
      || $past(commit, 3);
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt fell without a register write");
endmodule // epmt_chk

bind epmt_timer epmt_chk u_epmt_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .timer_io_pin_oe, .timer_out_pin_oe, .timer_irq);

/* bench/epmt_src.sv */
// Purpose: External pulse source driving the timer input pin.
// Assumes: Called from a process just after a rising pclk edge.
// Notes:   Widths are in pclk cycles; the pin idles low.
`timescale 1ns/1ps
module epmt_src (
  input  wire  pclk,
  output logic pin
);
  initial pin = 1'b0;

  // Callers keep both levels longer than one count-source period
  task automatic pulses(input int n, input int lo, input int hi);
    repeat (n) begin
      repeat (lo) @(posedge pclk);
      pin <= 1'b1;
      repeat (hi) @(posedge pclk);
      pin <= 1'b0;
    end
  endtask
endmodule // epmt_src

/* bench/epmt_timer_test.sv */
// Purpose: Self-checking bench for the event and pulse timer.
// Assumes: Timer pin activity comes from epmt_src; gate pin and link driven here; APB per the hand-over.
// Notes:   Random choices come from a fixed seed.
`timescale 1ns/1ps
module epmt_timer_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pin, io_out, io_oe, out_pin, out_oe, irq;
  logic        gate_pin = 1'b0, link = 1'b0, pready, pslverr, e, h;
  logic [3:0]  gate_pwm = 4'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q, n, gs;
  int          seed = 8114, err_total, comparisons, cyc, r, v, w;
  wire         io_w = io_oe ? io_out : pin;
  // Divided count sources and their ratios to pclk
  int          divs [3] = '{2, 8, 32};
  logic [2:0]  srcs [3] = '{3'h3, 3'h1, 3'h7};

  epmt_timer u_epmt_timer (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_io_pin_in(io_w),
    .timer_io_pin_out(io_out), .timer_io_pin_oe(io_oe),
    .timer_out_pin(out_pin), .timer_out_pin_oe(out_oe),
    .gate_int_pin(gate_pin), .gate_pwm(gate_pwm), .link_event(link),
    .timer_irq(irq));
  epmt_src u_epmt_src (.pclk(pclk), .pin(pin));

  always #2.5 pclk = ~pclk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
  end

  task automatic apb(input logic wr_n, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string s, input logic [31:0] x, y);
    comparisons++;
    if (y !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, y);
    end
  endtask
  // Registers change only while the count is stopped
  task automatic cfg(input logic [31:0] md, io, rl);
    wr(32'h0, 32'h0);
    wr(32'h4, io);
    wr(32'h8, md);
    wr(32'h10, gs);
    wr(32'hc, rl);
    wr(32'h0, 32'h1);
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    gs = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(32'h0);
    chk("ctrl_reset", 32'h0, q);
    rd(32'hc);
    chk("count_reset", 32'hffff, q);
    rd(32'h14);
    chk("unmapped_err", 32'h1, e);
    w = $random(seed);
    wr(32'h4, w);
    rd(32'h4);
    chk("ioc_rw", w & 32'h7f, q);
    $display("register tests done");
    for (int k = 0; k < 8; k++) begin
      r = 2 + {$random(seed)} % 3;
      cfg(32'h2, {25'h0, 1'b1, 2'h0, k[2:1], 1'b0, k[0]}, r);
      h = out_pin;
      chk("out_oe", 32'h1, out_oe);
      u_epmt_src.pulses(r + 1, 130, 130);
      repeat (150) @(posedge pclk);
      rd(32'hc);
      chk("event_count", r, q);
      chk("out_toggle", !h, out_pin);
    end
    for (int g = 1; g < 3; g++) begin
      gs = {$random(seed)} % 4;
      gate_pin <= g[1];
      gate_pwm <= ~(4'h1 << gs[1:0]);
      cfg(32'h2, {26'h0, g[1:0], 4'h0}, 32'hffff);
      u_epmt_src.pulses(3, 20, 20);
      repeat (10) @(posedge pclk);
      rd(32'hc);
      chk("gate_shut", 32'hffff, q);
      gate_pin <= g[0];
      gate_pwm <= 4'h1 << gs[1:0];
      u_epmt_src.pulses(3, 20, 20);
      repeat (10) @(posedge pclk);
      rd(32'hc);
      chk("gate_open", 32'hfffc, q);
    end
    $display("event tests done");
    gs = 32'h0;
    cfg(32'h1, 32'h0, 32'h40);
    chk("io_drive", 32'h1, io_oe);
    chk("io_vs_out", !out_pin, io_out);
    cfg(32'h1, 32'h2, 32'h40);
    chk("io_stop", 32'h0, io_oe);
    cfg(32'h50, 32'h0, 32'hffff);
    n = 1 + {$random(seed)} % 8;
    repeat (n) begin
      link <= 1'b1;
      repeat (2) @(posedge pclk);
      link <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    rd(32'hc);
    chk("link_count", 32'hffff - n, q);
    wr(32'h0, 32'h0);
    $display("pin and link tests done");
    // Low level active, idle pin low: counts with each divided source
    for (int c = 0; c < 3; c++) begin
      cfg({25'h0, srcs[c], 4'h3}, 32'h1, 32'hffff);
      repeat (16 * divs[c]) @(posedge pclk);
      wr(32'h0, 32'h0);
      rd(32'hc);
      v = 32'hffff - q;
      chk("divided_count", 32'h1, v >= 16 && v <= 20);
    end
    cfg(32'h3, 32'h0, 32'hffff);
    w = 30 + {$random(seed)} % 50;
    u_epmt_src.pulses(1, 10, w);
    repeat (10) @(posedge pclk);
    rd(32'hc);
    n = q;
    v = 32'hffff - q;
    chk("width", 32'h1, v >= w - 1 && v <= w + 1);
    repeat (20) @(posedge pclk);
    rd(32'hc);
    chk("width_held", n, q);
    rd(32'h0);
    chk("width_flags", 32'h13, q & 32'h33);
    chk("width_irq", 32'h1, irq);
    wr(32'h0, 32'h31);
    rd(32'h0);
    chk("flags_kept", 32'h13, q & 32'h33);
    wr(32'h0, 32'h1);
    rd(32'h0);
    chk("flags_clear", 32'h3, q & 32'h33);
    chk("irq_clear", 32'h0, irq);
    cfg(32'h3, 32'h0, 32'h8);
    u_epmt_src.pulses(1, 10, 40);
    repeat (10) @(posedge pclk);
    rd(32'h0);
    chk("width_underflow", 32'h33, q & 32'h33);
    $display("width tests done");
    cfg(32'h4, 32'h0, 32'hffff);
    w = 20 + {$random(seed)} % 20;
    fork
      begin
        u_epmt_src.pulses(1, 30, 30);
        u_epmt_src.pulses(2, w, w);
      end
    join_none
    repeat (42) @(posedge pclk);
    rd(32'hc);
    wait fork;
    repeat (10) @(posedge pclk);
    rd(32'hc);
    v = 32'hffff - q + 1;
    chk("period", 32'h1, v >= 28 + w && v <= 32 + w);
    rd(32'h0);
    chk("period_flag", 32'h13, q & 32'h13);
    chk("period_irq", 32'h1, irq);
    cfg(32'h4, 32'h0, 32'h10);
    repeat (40) @(posedge pclk);
    rd(32'h0);
    chk("period_underflow", 32'h20, q & 32'h20);
    $display("period tests done");
    conclude();
  end
endmodule // epmt_timer_test
